//--- logic/ref_clock_and_lock_monitor.sv
// reference input qualification and pll lock-loss reporting
`timescale 1ns/100ps
`default_nettype none
// What this block does
// [RQ1] inputs monitored alone; valid once enabled monitors stay clear long enough
// [RQ2] host uses only the phase-valid monitor on a 1-pps input
// [RQ3] disabled monitor never flags and is ignored for validation
// [RQ4] any flag selectable onto pins; status bits show selected input
// [RQ5] frequency flag clears below valid, sets above invalid threshold
// [RQ6] more accuracy or averaging slows measurement; averaging caps threshold
// [RQ7] edge by period plus late window clears; none sets flag
// [RQ8] host disables window checks below 2 kHz or above oscillator over 12
// [RQ9] late and early checks share one detector, flags ORed
// [RQ10] edge before period minus early window sets flag; later edge clears
// [RQ11] early check works only while late check is enabled
// [RQ12] 1-pps edge by period plus jitter clears; otherwise flag at once
// [RQ13] jitter threshold also bounds 1-pps frequency error
// [RQ14] enables, thresholds and validation times set per input
// [RQ15] analog loops report frequency loss; digital loops report both
// [RQ16] with resonator monitoring, third digital loop reports phase only
// [RQ17] digital frequency flag clears below lock, sets above unlock
// [RQ18] resonator vs xo with lock/unlock hysteresis
// [RQ19] digital phase flag clears below lock, sets above unlock
// [RQ20] all lock flags on status pins and status bits
// [RQ21] host never enables frequency and phase-valid monitors together
// [RQ22] counters on xo clock; flags registered before outputs
module ref_clock_and_lock_monitor
  import refmon_pkg::*;
#(
  parameter int TICK_CNT = refmon_pkg::TICK_CYCLES
)(
  input  wire logic                         ref_clk_i,
  input  wire logic                         rst_i,
  // asynchronous clock pins
  input  wire logic [refmon_pkg::NREF-1:0]  ref_in_i,
  input  wire logic                         resonator_oscillator_i,
  // per input config
  input  wire logic [refmon_pkg::NREF-1:0]  freq_en_i,
  input  wire logic [refmon_pkg::NREF-1:0]  late_en_i,
  input  wire logic [refmon_pkg::NREF-1:0]  early_en_i,
  input  wire logic [refmon_pkg::NREF-1:0]  pps_en_i,
  input  wire logic [refmon_pkg::CNT_W-1:0] period_i     [refmon_pkg::NREF],
  input  wire logic [refmon_pkg::CNT_W-1:0] late_win_i   [refmon_pkg::NREF],
  input  wire logic [refmon_pkg::CNT_W-1:0] early_win_i  [refmon_pkg::NREF],
  input  wire logic [refmon_pkg::CNT_W-1:0] pps_jitter_threshold_i [refmon_pkg::NREF],
  input  wire logic [refmon_pkg::THR_W-1:0] gate_base_i  [refmon_pkg::NREF],
  input  wire logic [refmon_pkg::THR_W-1:0] expect_base_i[refmon_pkg::NREF],
  input  wire logic [refmon_pkg::SH_W-1:0]  accuracy_i   [refmon_pkg::NREF],
  input  wire logic [refmon_pkg::SH_W-1:0]  averaging_i  [refmon_pkg::NREF],
  input  wire logic [refmon_pkg::THR_W-1:0] valid_thr_i  [refmon_pkg::NREF],
  input  wire logic [refmon_pkg::THR_W-1:0] invalid_thr_i[refmon_pkg::NREF],
  input  wire logic [refmon_pkg::VAL_W-1:0] valid_time_i [refmon_pkg::NREF],
  // loop errors, same clock
  input  wire logic [refmon_pkg::THR_W-1:0] apll_freq_err_i [2],
  input  wire logic [refmon_pkg::THR_W-1:0] apll_lock_thr_i [refmon_pkg::NLOOP],
  input  wire logic [refmon_pkg::THR_W-1:0] apll_unlock_thr_i[refmon_pkg::NLOOP],
  input  wire logic [refmon_pkg::THR_W-1:0] resonator_gate_i,
  input  wire logic [refmon_pkg::THR_W-1:0] resonator_expect_i,
  input  wire logic                         resonator_mon_sel_i,
  input  wire logic [refmon_pkg::NLOOP-1:0] dpll_en_i,
  input  wire logic [refmon_pkg::THR_W-1:0] dpll_freq_err_i  [refmon_pkg::NLOOP],
  input  wire logic [refmon_pkg::THR_W-1:0] dpll_phase_err_i [refmon_pkg::NLOOP],
  input  wire logic [refmon_pkg::THR_W-1:0] dfrq_lock_thr_i  [refmon_pkg::NLOOP],
  input  wire logic [refmon_pkg::THR_W-1:0] dfrq_unlock_thr_i[refmon_pkg::NLOOP],
  input  wire logic [refmon_pkg::THR_W-1:0] dphs_lock_thr_i  [refmon_pkg::NLOOP],
  input  wire logic [refmon_pkg::THR_W-1:0] dphs_unlock_thr_i[refmon_pkg::NLOOP],
  // status routing
  input  wire logic                         dpll_ref_sel_i [refmon_pkg::NLOOP],
  input  wire logic [refmon_pkg::SEL_W-1:0] status_pin_sel_i [2],
  output logic [1:0]                        status_pin_o,
  output logic [refmon_pkg::NREF-1:0]       ref_valid_o,
  output logic [refmon_pkg::NLOOP-1:0]      sel_ref_freq_fault_flag_o,
  output logic [refmon_pkg::NLOOP-1:0]      sel_ref_window_fault_flag_o,
  output logic [refmon_pkg::NLOOP-1:0]      sel_ref_pps_fault_flag_o,
  output logic [refmon_pkg::NLOOP-1:0]      apll_freq_lock_lost_flag_o,
  output logic [refmon_pkg::NLOOP-1:0]      dpll_freq_lock_lost_flag_o,
  output logic [refmon_pkg::NLOOP-1:0]      dpll_phase_lock_lost_flag_o,
  output logic [refmon_pkg::NLOOP-1:0]      lock_lost_indication_o
);
  import refmon_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // helpers

  // lock flag with hysteresis: clear below lock, set above unlock, else hold
  function automatic logic hyst(input logic flag, input logic [THR_W-1:0] err,
                                input logic [THR_W-1:0] lo, input logic [THR_W-1:0] hi);
    logic nxt;
    nxt = flag;
    if (err < lo) begin
      nxt = 1'b0;
    end else if (err > hi) begin
      nxt = 1'b1;
    end
    return nxt;
  endfunction

  // more averaging shrinks the largest usable threshold
  function automatic logic [CNT_W-1:0] thr_clamp(input logic [THR_W-1:0] thr,
                                                  input logic [SH_W-1:0] avg);
    logic [THR_W-1:0] lim;
    lim = THR_MAX >> avg;
    return {16'h0000, (thr > lim) ? lim : thr};
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers and edge detect

  logic [NREF-1:0] ref_s1_r;
  logic [NREF-1:0] ref_s2_r;
  logic [NREF-1:0] ref_s3_r;
  logic [NREF-1:0] ref_edge;
  logic            res_s1_r;
  logic            res_s2_r;
  logic            res_s3_r;
  logic            res_edge;

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      ref_s1_r <= '0;
      ref_s2_r <= '0;
      ref_s3_r <= '0;
      res_s1_r <= 1'b0;
      res_s2_r <= 1'b0;
      res_s3_r <= 1'b0;
    end else begin
      ref_s1_r <= ref_in_i;
      ref_s2_r <= ref_s1_r;
      ref_s3_r <= ref_s2_r;
      res_s1_r <= resonator_oscillator_i;
      res_s2_r <= res_s1_r;
      res_s3_r <= res_s2_r;
    end
  end

  assign ref_edge = ref_s2_r & ~ref_s3_r;
  assign res_edge = res_s2_r & ~res_s3_r;

  ////////////////////////////////////////////////////////////////////////////
  // millisecond tick for the validation timers

  logic [CNT_W-1:0] tick_cnt_r;
  logic             tick_r;

  always_ff @(posedge ref_clk_i) begin
    if (rst_i || tick_cnt_r == CNT_W'(TICK_CNT - 1)) begin
      tick_cnt_r <= '0;
    end else begin
      tick_cnt_r <= tick_cnt_r + 32'h00000001;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      tick_r <= 1'b0;
    end else begin
      tick_r <= (tick_cnt_r == CNT_W'(TICK_CNT - 1));
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // per input monitors and validation

  logic [NREF-1:0] freq_flag;
  logic [NREF-1:0] late_flag;
  logic [NREF-1:0] early_flag;
  logic [NREF-1:0] pps_flag;
  logic [NREF-1:0] win_flag;
  logic [NREF-1:0] any_flag;
  logic [NREF-1:0] valid_r;

  genvar g;
  generate
    for (g = 0; g < NREF; g++) begin : g_ref
      logic [VAL_W-1:0] clean_ms_r;
      logic [CNT_W-1:0] gate;
      logic [CNT_W-1:0] expect_cnt;

      // accuracy and averaging widen the gate
      assign gate       = {16'h0000, gate_base_i[g]} << (accuracy_i[g] + averaging_i[g]); // RQ6
      assign expect_cnt = {16'h0000, expect_base_i[g]} << (accuracy_i[g] + averaging_i[g]);

      freq_offset_mon u_freq (
        .ref_clk_i   (ref_clk_i),
        .rst_i       (rst_i),
        .en_i        (freq_en_i[g]),
        .edge_i      (ref_edge[g]),
        .gate_i      (gate),
        .expect_i    (expect_cnt),
        .clear_thr_i (thr_clamp(valid_thr_i[g], averaging_i[g])),   // RQ5 RQ6
        .set_thr_i   (thr_clamp(invalid_thr_i[g], averaging_i[g])),
        .flag_o      (freq_flag[g])
      );

      edge_window_det u_win (
        .ref_clk_i              (ref_clk_i),
        .rst_i                  (rst_i),
        .edge_i                 (ref_edge[g]),
        .late_en_i              (late_en_i[g]),
        .early_en_i             (early_en_i[g]),
        .pps_en_i               (pps_en_i[g]),
        .period_i               (period_i[g]),
        .late_win_i             (late_win_i[g]),
        .early_win_i            (early_win_i[g]),
        .pps_jitter_threshold_i (pps_jitter_threshold_i[g]),
        .late_flag_o            (late_flag[g]),
        .early_flag_o           (early_flag[g]),
        .pps_flag_o             (pps_flag[g])
      );

      assign win_flag[g] = late_flag[g] | early_flag[g]; // RQ9
      // disabled monitors already hold their flags low
      assign any_flag[g] = freq_flag[g] | win_flag[g] | pps_flag[g]; // RQ3

      // any flag restarts the clean time
      always_ff @(posedge ref_clk_i) begin
        if (rst_i || any_flag[g]) begin
          clean_ms_r <= '0; // RQ1
        end else if (tick_r && clean_ms_r != valid_time_i[g]) begin
          clean_ms_r <= clean_ms_r + 16'h0001; // RQ14
        end
      end

      always_ff @(posedge ref_clk_i) begin
        if (rst_i || any_flag[g]) begin
          valid_r[g] <= 1'b0;
        end else begin
          valid_r[g] <= (clean_ms_r == valid_time_i[g]); // RQ1
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // lock detectors

  logic [NLOOP-1:0] apll_lol_r;
  logic [NLOOP-1:0] dfrq_lol_r;
  logic [NLOOP-1:0] dphs_lol_r;
  logic             res_flag;

  // resonator counted against the xo
  freq_offset_mon u_res (
    .ref_clk_i   (ref_clk_i),
    .rst_i       (rst_i),
    .en_i        (resonator_mon_sel_i),
    .edge_i      (res_edge),
    .gate_i      ({16'h0000, resonator_gate_i}),
    .expect_i    ({16'h0000, resonator_expect_i}),
    .clear_thr_i ({16'h0000, apll_lock_thr_i[2]}),   // RQ18
    .set_thr_i   ({16'h0000, apll_unlock_thr_i[2]}),
    .flag_o      (res_flag)
  );

  generate
    for (g = 0; g < NLOOP; g++) begin : g_loop
      if (g < 2) begin : g_apll
        always_ff @(posedge ref_clk_i) begin
          if (rst_i) begin
            apll_lol_r[g] <= FLAG_RST;
          end else begin
            apll_lol_r[g] <= hyst(apll_lol_r[g], apll_freq_err_i[g],
                                  apll_lock_thr_i[g], apll_unlock_thr_i[g]); // RQ15
          end
        end
      end else begin : g_res
        always_ff @(posedge ref_clk_i) begin
          if (rst_i) begin
            apll_lol_r[g] <= FLAG_RST;
          end else begin
            apll_lol_r[g] <= resonator_mon_sel_i & res_flag; // RQ18
          end
        end
      end

      // loop 3 yields its freq flag to the resonator check
      always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
          dfrq_lol_r[g] <= FLAG_RST;
        end else if (g == NLOOP - 1 && resonator_mon_sel_i) begin
          dfrq_lol_r[g] <= 1'b0; // RQ16
        end else begin
          dfrq_lol_r[g] <= hyst(dfrq_lol_r[g], dpll_freq_err_i[g],
                                dfrq_lock_thr_i[g], dfrq_unlock_thr_i[g]); // RQ17
        end
      end

      always_ff @(posedge ref_clk_i) begin
        if (rst_i || !dpll_en_i[g]) begin
          dphs_lol_r[g] <= FLAG_RST;
        end else begin
          dphs_lol_r[g] <= hyst(dphs_lol_r[g], dpll_phase_err_i[g],
                                dphs_lock_thr_i[g], dphs_unlock_thr_i[g]); // RQ19
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // status routing

  logic [NFLAG-1:0] flags;

  always_comb begin
    flags = '0;
    for (int i = 0; i < NREF; i++) begin
      flags[i*FLG_PER_REF + FLG_FREQ]    = freq_flag[i];
      flags[i*FLG_PER_REF + FLG_WIN]     = win_flag[i];
      flags[i*FLG_PER_REF + FLG_PPS]     = pps_flag[i];
      flags[i*FLG_PER_REF + FLG_INVALID] = ~valid_r[i];
    end
    for (int i = 0; i < NLOOP; i++) begin
      flags[FLG_APLL_BASE + i] = apll_lol_r[i];
      flags[FLG_DFRQ_BASE + i] = dfrq_lol_r[i];
      flags[FLG_DPHS_BASE + i] = dphs_lol_r[i];
    end
  end

  // out-of-range selections read as zero
  always_ff @(posedge ref_clk_i) begin
    for (int p = 0; p < 2; p++) begin
      if (rst_i || status_pin_sel_i[p] >= SEL_W'(NFLAG)) begin
        status_pin_o[p] <= 1'b0;
      end else begin
        status_pin_o[p] <= flags[status_pin_sel_i[p]]; // RQ4 RQ20
      end
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      ref_valid_o <= '0;
    end else begin
      ref_valid_o <= valid_r;
    end
  end

  // status bits follow each loop's selected input
  always_ff @(posedge ref_clk_i) begin
    for (int l = 0; l < NLOOP; l++) begin
      if (rst_i) begin
        sel_ref_freq_fault_flag_o[l]   <= 1'b0;
        sel_ref_window_fault_flag_o[l] <= 1'b0;
        sel_ref_pps_fault_flag_o[l]    <= 1'b0;
      end else begin
        sel_ref_freq_fault_flag_o[l]   <= freq_flag[dpll_ref_sel_i[l]]; // RQ4
        sel_ref_window_fault_flag_o[l] <= win_flag[dpll_ref_sel_i[l]];  // RQ9
        sel_ref_pps_fault_flag_o[l]    <= pps_flag[dpll_ref_sel_i[l]];
      end
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      apll_freq_lock_lost_flag_o  <= {NLOOP{FLAG_RST}};
      dpll_freq_lock_lost_flag_o  <= {NLOOP{FLAG_RST}};
      dpll_phase_lock_lost_flag_o <= {NLOOP{FLAG_RST}};
      lock_lost_indication_o      <= {NLOOP{FLAG_RST}};
    end else begin
      apll_freq_lock_lost_flag_o  <= apll_lol_r;             // RQ20
      dpll_freq_lock_lost_flag_o  <= dfrq_lol_r;             // RQ20
      dpll_phase_lock_lost_flag_o <= dphs_lol_r;             // RQ20
      lock_lost_indication_o      <= dfrq_lol_r | dphs_lol_r; // RQ15
    end
  end
endmodule
`default_nettype wire

//--- logic/refmon_pkg.sv
// shared constants for the reference clock and lock monitor
package refmon_pkg;
  localparam int NREF          = 2;
  localparam int NLOOP         = 3;
  localparam int CNT_W         = 32;
  localparam int THR_W         = 16;
  localparam int SH_W          = 4;
  localparam int VAL_W         = 16;
  localparam int SEL_W         = 5;
  localparam int NFLAG         = 17;
  // validation timer counts in milliseconds
  localparam int CLK_FREQ_KHZ  = 100000;
  localparam int TICK_TIME_MS  = 1;
  localparam int TICK_CYCLES   = TICK_TIME_MS * CLK_FREQ_KHZ;
  localparam logic [THR_W-1:0] THR_MAX   = 16'hffff;
  localparam logic [CNT_W-1:0] CNT_SAT   = 32'hffffffff;
  localparam logic             FLAG_RST  = 1'b1;
  // flag vector positions: per input four flags, then loop flags
  localparam int FLG_FREQ      = 0;
  localparam int FLG_WIN       = 1;
  localparam int FLG_PPS       = 2;
  localparam int FLG_INVALID   = 3;
  localparam int FLG_PER_REF   = 4;
  localparam int FLG_APLL_BASE = 8;
  localparam int FLG_DFRQ_BASE = 11;
  localparam int FLG_DPHS_BASE = 14;
endpackage

//--- logic/edge_window_det.sv
// window detector shared by late, early and 1-pps checks of one input
`timescale 1ns/100ps
`default_nettype none
module edge_window_det
  import refmon_pkg::*;
(
  input  wire logic             ref_clk_i,
  input  wire logic             rst_i,
  input  wire logic             edge_i,
  input  wire logic             late_en_i,
  input  wire logic             early_en_i,
  input  wire logic             pps_en_i,
  input  wire logic [CNT_W-1:0] period_i,
  input  wire logic [CNT_W-1:0] late_win_i,
  input  wire logic [CNT_W-1:0] early_win_i,
  input  wire logic [CNT_W-1:0] pps_jitter_threshold_i,
  output logic                  late_flag_o,
  output logic                  early_flag_o,
  output logic                  pps_flag_o
);
  import refmon_pkg::*;

  logic [CNT_W-1:0] since_r;
  logic [CNT_W:0]   late_lim;
  logic [CNT_W:0]   pps_lim;
  logic [CNT_W-1:0] early_lim;

  // late and 1-pps limits are one bit wider so a large window cannot wrap
  assign late_lim  = {1'b0, period_i} + {1'b0, late_win_i};
  assign pps_lim   = {1'b0, period_i} + {1'b0, pps_jitter_threshold_i};
  assign early_lim = (early_win_i > period_i) ? '0 : period_i - early_win_i;

  // cycles since the last edge, saturating
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      since_r <= '0;
    end else if (edge_i) begin
      since_r <= 32'h00000001;
    end else if (since_r != CNT_SAT) begin
      since_r <= since_r + 32'h00000001;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i || !late_en_i) begin
      late_flag_o <= 1'b0; // RQ3
    end else if (edge_i && ({1'b0, since_r} <= late_lim)) begin
      late_flag_o <= 1'b0; // RQ7
    end else if ({1'b0, since_r} > late_lim) begin
      late_flag_o <= 1'b1; // RQ7
    end
  end

  // early check runs only together with the late check
  always_ff @(posedge ref_clk_i) begin
    if (rst_i || !early_en_i || !late_en_i) begin
      early_flag_o <= 1'b0; // RQ11
    end else if (edge_i) begin
      early_flag_o <= (since_r < early_lim); // RQ10
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i || !pps_en_i) begin
      pps_flag_o <= 1'b0; // RQ3
    end else if (edge_i && ({1'b0, since_r} <= pps_lim)) begin
      pps_flag_o <= 1'b0; // RQ12
    end else if ({1'b0, since_r} > pps_lim) begin
      pps_flag_o <= 1'b1; // RQ12 RQ13
    end
  end
endmodule
`default_nettype wire

//--- logic/freq_offset_mon.sv
// gated edge counter comparing a clock against the xo with hysteresis
`timescale 1ns/100ps
`default_nettype none
module freq_offset_mon
  import refmon_pkg::*;
(
  input  wire logic             ref_clk_i,
  input  wire logic             rst_i,
  input  wire logic             en_i,
  input  wire logic             edge_i,
  input  wire logic [CNT_W-1:0] gate_i,
  input  wire logic [CNT_W-1:0] expect_i,
  input  wire logic [CNT_W-1:0] clear_thr_i,
  input  wire logic [CNT_W-1:0] set_thr_i,
  output logic                  flag_o
);
  import refmon_pkg::*;

  logic [CNT_W-1:0] gate_r;
  logic [CNT_W-1:0] edges_r;
  logic [CNT_W-1:0] err;
  logic             gate_end;

  assign gate_end = (gate_r >= gate_i);
  assign err = (edges_r > expect_i) ? edges_r - expect_i : expect_i - edges_r;

  // xo cycles form the gate; a longer gate means slower reaction
  always_ff @(posedge ref_clk_i) begin
    if (rst_i || !en_i || gate_end) begin
      gate_r <= 32'h00000001; // RQ6 RQ22
    end else begin
      gate_r <= gate_r + 32'h00000001;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i || !en_i || gate_end) begin
      edges_r <= {31'h0, edge_i && en_i && !rst_i};
    end else if (edge_i && edges_r != CNT_SAT) begin
      edges_r <= edges_r + 32'h00000001;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      flag_o <= 1'b0;
    end else if (!en_i) begin
      flag_o <= 1'b0; // RQ3
    end else if (gate_end && err < clear_thr_i) begin
      flag_o <= 1'b0; // RQ5
    end else if (gate_end && err > set_thr_i) begin
      flag_o <= 1'b1; // RQ5
    end
  end
endmodule
`default_nettype wire

//--- bench/refmon_properties.sv
// port assertions
`timescale 1ns/100ps
`default_nettype none
module refmon_properties
  import refmon_pkg::*;
(
  input wire logic             ref_clk_i,
  input wire logic             rst_i,
  input wire logic [NREF-1:0]  late_en_i,
  input wire logic             dpll_ref_sel_i [NLOOP],
  input wire logic [NLOOP-1:0] dpll_en_i,
  input wire logic             resonator_mon_sel_i,
  input wire logic [THR_W-1:0] dpll_freq_err_i [NLOOP],
  input wire logic [THR_W-1:0] dpll_phase_err_i [NLOOP],
  input wire logic [THR_W-1:0] dfrq_lock_thr_i [NLOOP],
  input wire logic [THR_W-1:0] dfrq_unlock_thr_i [NLOOP],
  input wire logic [THR_W-1:0] dphs_lock_thr_i [NLOOP],
  input wire logic [SEL_W-1:0] status_pin_sel_i [2],
  input wire logic [1:0]       status_pin_o,
  input wire logic [NLOOP-1:0] sel_ref_window_fault_flag_o,
  input wire logic [NLOOP-1:0] apll_freq_lock_lost_flag_o,
  input wire logic [NLOOP-1:0] dpll_freq_lock_lost_flag_o,
  input wire logic [NLOOP-1:0] dpll_phase_lock_lost_flag_o
);
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);
  ////////////////////////////////////////////////////////////////
  // three samples of a steady cause cover both register stages
  property p_fclr; (dpll_freq_err_i[0] < dfrq_lock_thr_i[0]) [*3] |=> !dpll_freq_lock_lost_flag_o[0]; endproperty
  a_fclr: assert property (p_fclr) else $error("freq flag stuck");
  property p_fset; (dpll_freq_err_i[0] > dfrq_unlock_thr_i[0]) [*3] |=> dpll_freq_lock_lost_flag_o[0]; endproperty
  a_fset: assert property (p_fset) else $error("freq flag missed");
  property p_pclr; (dpll_en_i[0] && dpll_phase_err_i[0] < dphs_lock_thr_i[0]) [*3] |=> !dpll_phase_lock_lost_flag_o[0]; endproperty
  a_pclr: assert property (p_pclr) else $error("phase flag stuck");
  property p_poff; (!dpll_en_i[1]) [*3] |=> dpll_phase_lock_lost_flag_o[1]; endproperty
  a_poff: assert property (p_poff) else $error("idle loop locked");
  property p_rsel; resonator_mon_sel_i [*3] |=> !dpll_freq_lock_lost_flag_o[2]; endproperty
  a_rsel: assert property (p_rsel) else $error("loop3 freq shown");
  property p_aoff; (!resonator_mon_sel_i) [*3] |=> !apll_freq_lock_lost_flag_o[2]; endproperty
  a_aoff: assert property (p_aoff) else $error("resonator flag shown");
  property p_woff; (!late_en_i[0] && !dpll_ref_sel_i[0]) [*3] |=> !sel_ref_window_fault_flag_o[0]; endproperty
  a_woff: assert property (p_woff) else $error("disabled window flag");
  property p_poff2; (status_pin_sel_i[1] >= 5'h11) [*3] |=> !status_pin_o[1]; endproperty
  a_poff2: assert property (p_poff2) else $error("unused pin high");
  c_win: cover property ($rose(sel_ref_window_fault_flag_o[0]));
  c_lock: cover property ($fell(dpll_freq_lock_lost_flag_o[0]));
  c_pin: cover property ($rose(status_pin_o[0]));
endmodule
`default_nettype wire

//--- bench/ref_source.sv
// clock source, still while disabled
`timescale 1ns/100ps
`default_nettype none
module ref_source (
  input  wire logic       clk_i,
  input  wire logic       en_i,
  input  wire logic [7:0] half_i,
  output logic            ref_o
);
  logic [7:0] cnt_r;
  // bench takes ref 0 to 10 cycles per period with window checks on, above their range
  always_ff @(posedge clk_i) begin
    if (!en_i) begin
      cnt_r <= 8'h00;
      ref_o <= 1'b0;
    end else if (cnt_r + 8'h01 >= half_i) begin
      cnt_r <= 8'h00;
      ref_o <= !ref_o;
    end else begin
      cnt_r <= cnt_r + 8'h01;
    end
  end
endmodule
`default_nettype wire

//--- bench/tb.sv
// self-checking bench
`timescale 1ns/100ps
`default_nettype none
module tb;
  import refmon_pkg::*;
  localparam logic [15:0] TBL [4] = '{16'h0a, 16'h05, 16'h01, 16'h05};
  localparam logic [3:0]  EXPV    = 4'b0011;
  logic             ref_clk_i, rst_i, resonator_mon_sel_i, resonator_oscillator_i;
  logic             dpll_ref_sel_i [NLOOP];
  logic [1:0]       r, freq_en_i, late_en_i, early_en_i, pps_en_i, ref_valid_o, status_pin_o;
  logic [2:0]       en, dpll_en_i, sel_ref_freq_fault_flag_o, sel_ref_window_fault_flag_o;
  logic [2:0]       sel_ref_pps_fault_flag_o, apll_freq_lock_lost_flag_o, lock_lost_indication_o;
  logic [2:0]       dpll_freq_lock_lost_flag_o, dpll_phase_lock_lost_flag_o;
  logic [7:0]       half [3];
  logic [CNT_W-1:0] period_i [2], late_win_i [2], early_win_i [2], pps_jitter_threshold_i [2];
  logic [THR_W-1:0] gate_base_i [2], expect_base_i [2], valid_thr_i [2], invalid_thr_i [2];
  logic [THR_W-1:0] apll_freq_err_i [2], apll_lock_thr_i [3], apll_unlock_thr_i [3];
  logic [THR_W-1:0] dpll_freq_err_i [3], dpll_phase_err_i [3], dfrq_lock_thr_i [3];
  logic [THR_W-1:0] dfrq_unlock_thr_i [3], dphs_lock_thr_i [3], dphs_unlock_thr_i [3];
  logic [THR_W-1:0] resonator_gate_i, resonator_expect_i;
  logic [SH_W-1:0]  accuracy_i [2], averaging_i [2];
  logic [VAL_W-1:0] valid_time_i [2];
  logic [SEL_W-1:0] status_pin_sel_i [2];
  int               fail_count, check_count;
  ref_source rs0 (.clk_i(ref_clk_i), .en_i(en[0]), .half_i(half[0]), .ref_o(r[0]));
  ref_source rs1 (.clk_i(ref_clk_i), .en_i(en[1]), .half_i(half[1]), .ref_o(r[1]));
  ref_source rs2 (.clk_i(ref_clk_i), .en_i(en[2]), .half_i(half[2]), .ref_o(resonator_oscillator_i));
  ref_clock_and_lock_monitor #(.TICK_CNT(10)) uut (.*, .ref_in_i(r));
  ////////////////////////////////////////////////////////////////
  initial begin
    ref_clk_i = 1'b0;
    forever #5 ref_clk_i = !ref_clk_i;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk_i);
    #1;
  endtask
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    check_count++;
    if (g !== e) begin
      fail_count++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic print_verdict();
    $display("checks %0d errors %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  function automatic logic pick(input int s);
    if (s == 0) return ref_valid_o[0];
    if (s == 1) return sel_ref_window_fault_flag_o[0];
    return sel_ref_freq_fault_flag_o[1];
  endfunction
  // a wait that runs out is a mismatch and ends the run
  task automatic wait_for(input int s, input logic v, input int lim);
    int k;
    for (k = 0; k < lim && pick(s) !== v; k++) tick(1);
    chk("wait", 8'(v), 8'(pick(s)));
    if (k == lim) print_verdict();
  endtask
  ////////////////////////////////////////////////////////////////
  initial begin
    fail_count = 0;
    check_count = 0;
    rst_i = 1'b1;
    en = 3'h0;
    half = '{8'h0a, 8'h05, 8'h04};
    {freq_en_i, late_en_i, early_en_i, pps_en_i} = 8'h00;
    resonator_mon_sel_i = 1'b0;
    dpll_en_i = 3'h5;
    dpll_ref_sel_i = '{1'b0, 1'b1, 1'b0};
    status_pin_sel_i = '{5'h04, 5'h1f};
    apll_freq_err_i = '{16'h00, 16'h00};
    resonator_gate_i = 16'h64;
    resonator_expect_i = 16'h0c;
    for (int i = 0; i < 2; i++) begin
      period_i[i] = 32'h14;
      late_win_i[i] = 32'h04;
      early_win_i[i] = 32'h04;
      pps_jitter_threshold_i[i] = 32'h04;
      gate_base_i[i] = 16'h64;
      expect_base_i[i] = 16'h0a;
      {accuracy_i[i], averaging_i[i]} = 8'h00;
      valid_thr_i[i] = 16'h02;
      invalid_thr_i[i] = 16'h04;
      valid_time_i[i] = 16'h02;
    end
    for (int i = 0; i < 3; i++) begin
      {dpll_freq_err_i[i], dpll_phase_err_i[i]} = 32'h0;
      {dfrq_lock_thr_i[i], dphs_lock_thr_i[i], apll_lock_thr_i[i]} = {3{16'h03}};
      {dfrq_unlock_thr_i[i], dphs_unlock_thr_i[i], apll_unlock_thr_i[i]} = {3{16'h08}};
    end
    tick(8);
    chk("lol", 8'h07, 8'(lock_lost_indication_o));
    chk("valid", 8'h00, 8'(ref_valid_o));
    rst_i = 1'b0;
    tick(4);
    en = 3'h7;
    late_en_i = 2'h1;
    early_en_i = 2'h1;
    freq_en_i = 2'h2;
    wait_for(0, 1'b1, 400);
    en[0] = 1'b0;
    wait_for(1, 1'b1, 60);
    tick(1);
    chk("valid", 8'h00, 8'(ref_valid_o[0]));
    en[0] = 1'b1;
    wait_for(1, 1'b0, 80);
    half[0] = 8'h05;
    wait_for(1, 1'b1, 60);
    late_en_i[0] = 1'b0;
    tick(10);
    chk("early alone", 8'h00, 8'(sel_ref_window_fault_flag_o[0]));
    wait_for(2, 1'b0, 600);
    expect_base_i[1] = 16'h14;
    wait_for(2, 1'b1, 600);
    tick(3);
    chk("pin", 8'h01, 8'(status_pin_o));
    resonator_mon_sel_i = 1'b1;
    dpll_freq_err_i[2] = 16'h0a;
    tick(300);
    chk("res", 8'h00, 8'(apll_freq_lock_lost_flag_o[2]));
    chk("d3f", 8'h00, 8'(dpll_freq_lock_lost_flag_o[2]));
    for (int i = 0; i < 4; i++) begin
      {dpll_freq_err_i[0], dpll_phase_err_i[0], apll_freq_err_i[0]} = {3{TBL[i]}};
      tick(5);
      chk("dfrq", 8'(EXPV[i]), 8'(dpll_freq_lock_lost_flag_o[0]));
      chk("dphs", 8'(EXPV[i]), 8'(dpll_phase_lock_lost_flag_o[0]));
      chk("apll", 8'(EXPV[i]), 8'(apll_freq_lock_lost_flag_o[0]));
    end
    chk("lol", 8'h02, 8'(lock_lost_indication_o));
    chk("pps", 8'h00, 8'(sel_ref_pps_fault_flag_o));
    print_verdict();
  end
endmodule
bind ref_clock_and_lock_monitor refmon_properties chk_i (.*);
`default_nettype wire
